// ==== verilog/escb_cfg.svh ====
`ifndef ESCB_CFG_SVH
`define ESCB_CFG_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ESCB_OFF_STATE   8'h04
`define ESCB_OFF_VBASE   8'h08
`define ESCB_OFF_IRQST   8'h0C
`define ESCB_OFF_IRQMSK  8'h10
// ----------------------------------------
// field positions
// ----------------------------------------
`define ESCB_B_NMI_SET   31
`define ESCB_B_DSC_SET   28
`define ESCB_B_DSC_CLR   27
`define ESCB_B_TCK_SET   26
`define ESCB_B_TCK_CLR   25
`define ESCB_B_DEBUG     23
`define ESCB_B_ANYPEND   22
`define ESCB_B_PEND_HI   20
`define ESCB_B_PEND_LO   12
`define ESCB_B_RETBASE   11
`define ESCB_B_ACT_HI    8
`define ESCB_B_ACT_LO    0
`define ESCB_B_TBL_HI    31
`define ESCB_B_TBL_LO    9
// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define ESCB_RST_WORD    32'h0000_0000
`define ESCB_RST_EVT     3'h0
`define ESCB_EXC_NMI     9'h002
`define ESCB_EXC_DSC     9'h00E
`define ESCB_EXC_TICK    9'h00F
`define ESCB_EXC_NONE    9'h000
`define ESCB_VB_LOW      9'h000
`define ESCB_STATE_RSVD  32'h6B20_0600
`endif

// ==== verilog/escb_pkg.sv ====
package escb_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } escb_req_t;
    typedef struct packed {
        logic       in_handler;
        logic       preempted;
        logic [8:0] interrupt_program_status_num;
        logic [8:0] top_pend;
        logic       top_is_fault;
        logic       ext_irq_pend;
    } escb_core_t;
    typedef enum logic [1:0] {
        ESCB_EV_NMI, ESCB_EV_DSC, ESCB_EV_TICK
    } escb_ev_t;
endpackage

// ==== verilog/escb_ctrl.sv ====
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "escb_cfg.svh"
// ----------------------------------------
// Behaviour
// - write one to bit 31 pends unmaskable interrupt; read shows its pending state
// - entering unmaskable handler clears pending; re-assertion during handler sets it again
// - write one to bit 28 pends deferred call; read shows pending
// - only a software write sets deferred call pending
// - bit 27 write-only; one clears deferred call pending
// - write one to bit 26 pends tick; read shows pending
// - bit 25 write-only; one clears tick pending; reads zero here
// - bit 23 reads zero outside debug state
// - bit 22 shows any interrupt pending, excluding unmaskable and faults
// - bits 20:12 show top pending enabled exception number, zero if none
// - top pending number honours base threshold and fault mask, not general mask
// - bit 11 zero while preempted active exceptions remain
// - bits 8:0 hold active exception number, zero in thread mode
// - active number equals low nine bits of program status
// - vector base bits 31:9 hold table offset bits 31:9
// - low nine bits of vector base always zero
// ----------------------------------------
module escb_ctrl
    import escb_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        nmi_pin,
    input  wire logic        nmi_entry,
    input  wire logic        dsc_entry,
    input  wire logic        tick_event,
    input  wire logic        tick_entry,
    input  wire logic [8:0]  interrupt_program_status_num,
    input  wire logic        preempted,
    input  wire logic [8:0]  top_pend,
    input  wire logic        top_is_fault,
    input  wire logic        ext_irq_pend,
    input  wire logic        debug_state,
    output logic             nmi_pend,
    output logic             dsc_pend,
    output logic             tick_pend,
    output logic      [31:0] vector_base,
    output logic             irq
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] nmi_sync_ff;
    logic       nmi_prev_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_sync_ff <= 2'h0;
            nmi_prev_ff <= 1'h0;
        end else if (clk_en) begin
            nmi_sync_ff <= {nmi_sync_ff[0], nmi_pin};
            nmi_prev_ff <= nmi_sync_ff[1];
        end
    end
    logic nmi_rise;
    assign nmi_rise = nmi_sync_ff[1] & ~nmi_prev_ff;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    // bundling the bus and core views keeps decode and state word on one naming scheme
    escb_req_t  bus_req;
    escb_core_t core_view;
    always_comb begin
        bus_req.addr  = reg_addr;
        bus_req.wdata = reg_wdata;
        bus_req.wr    = reg_wr;
        bus_req.rd    = reg_rd;
    end
    always_comb begin
        core_view.in_handler   = (interrupt_program_status_num != `ESCB_EXC_NONE);
        core_view.preempted    = preempted;
        core_view.interrupt_program_status_num     = interrupt_program_status_num;
        core_view.top_pend     = top_pend;
        core_view.top_is_fault = top_is_fault;
        core_view.ext_irq_pend = ext_irq_pend;
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction
    // the low offset bits are tied off here so no path can ever load them
    function automatic logic [31:0] vbase_word(input logic [`ESCB_B_TBL_HI:`ESCB_B_TBL_LO] t);
        vbase_word = {t, `ESCB_VB_LOW};
    endfunction
    logic wr_state, wr_vbase, wr_msk, rd_irqst;
    assign wr_state = clk_en & bus_req.wr & hit(bus_req.addr, `ESCB_OFF_STATE);
    assign wr_vbase = clk_en & bus_req.wr & hit(bus_req.addr, `ESCB_OFF_VBASE);
    assign wr_msk   = clk_en & bus_req.wr & hit(bus_req.addr, `ESCB_OFF_IRQMSK);
    assign rd_irqst = clk_en & bus_req.rd & hit(bus_req.addr, `ESCB_OFF_IRQST);

    // ----------------------------------------
    // pending state
    // ----------------------------------------
    logic nmi_pend_ff, dsc_pend_ff, tick_pend_ff;
    logic nxt_nmi, nxt_dsc, nxt_tick;
    always_comb begin
        nxt_nmi = nmi_pend_ff;
        // entry clears; a fresh assertion or write in the same cycle still wins
        if (nmi_entry)
            nxt_nmi = 1'b0;
        if (nmi_rise)
            nxt_nmi = 1'b1;
        if (wr_state && reg_wdata[`ESCB_B_NMI_SET])
            nxt_nmi = 1'b1;
    end
    always_comb begin
        nxt_dsc = dsc_pend_ff;
        if (dsc_entry)
            nxt_dsc = 1'b0;
        if (wr_state && reg_wdata[`ESCB_B_DSC_CLR])
            nxt_dsc = 1'b0;
        // set written last: both at once is undefined, set chosen
        if (wr_state && reg_wdata[`ESCB_B_DSC_SET])
            nxt_dsc = 1'b1;
    end
    always_comb begin
        nxt_tick = tick_pend_ff;
        if (tick_entry)
            nxt_tick = 1'b0;
        if (wr_state && reg_wdata[`ESCB_B_TCK_CLR])
            nxt_tick = 1'b0;
        if (tick_event)
            nxt_tick = 1'b1;
        if (wr_state && reg_wdata[`ESCB_B_TCK_SET])
            nxt_tick = 1'b1;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_pend_ff  <= 1'b0;
            dsc_pend_ff  <= 1'b0;
            tick_pend_ff <= 1'b0;
        end else if (clk_en) begin
            nmi_pend_ff  <= nxt_nmi;
            dsc_pend_ff  <= nxt_dsc;
            tick_pend_ff <= nxt_tick;
        end
    end

    // ----------------------------------------
    // vector base
    // ----------------------------------------
    logic [`ESCB_B_TBL_HI:`ESCB_B_TBL_LO] tbl_ff;
    logic [`ESCB_B_TBL_HI:`ESCB_B_TBL_LO] nxt_tbl;
    // alignment is software's duty; the low bits are simply never stored
    always_comb begin
        nxt_tbl = tbl_ff;
        if (wr_vbase)
            nxt_tbl = reg_wdata[`ESCB_B_TBL_HI:`ESCB_B_TBL_LO];
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            tbl_ff <= '0;
        else if (clk_en)
            tbl_ff <= nxt_tbl;
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    logic [2:0] evt_ff, msk_ff;
    logic [2:0] evt_set, nxt_evt, nxt_msk;
    assign evt_set = {nxt_tick & ~tick_pend_ff, nxt_dsc & ~dsc_pend_ff, nxt_nmi & ~nmi_pend_ff};
    always_comb begin
        // a new event in the clearing read's cycle survives: set beats read-clear
        nxt_evt = (rd_irqst ? `ESCB_RST_EVT : evt_ff) | evt_set;
    end
    always_comb begin
        nxt_msk = msk_ff;
        if (wr_msk)
            nxt_msk = reg_wdata[2:0];
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            evt_ff <= `ESCB_RST_EVT;
        else if (clk_en)
            evt_ff <= nxt_evt;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            msk_ff <= `ESCB_RST_EVT;
        else if (clk_en)
            msk_ff <= nxt_msk;
    end
    // next-state mask keeps the pin in step with a mask write, no stale cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            irq <= 1'b0;
        else if (clk_en)
            irq <= |(nxt_evt & nxt_msk);
    end

    // ----------------------------------------
    // state word and read mux
    // ----------------------------------------
    logic [31:0] state_word;
    always_comb begin
        state_word = `ESCB_RST_WORD;
        state_word[`ESCB_B_NMI_SET] = nmi_pend_ff;
        state_word[`ESCB_B_DSC_SET] = dsc_pend_ff;
        state_word[`ESCB_B_TCK_SET] = tick_pend_ff;
        state_word[`ESCB_B_DEBUG]   = 1'b0;
        // core view gives unmaskable/fault-free pending for the flag
        state_word[`ESCB_B_ANYPEND] = core_view.ext_irq_pend | tick_pend_ff | dsc_pend_ff;
        // core supplies number already filtered by threshold and fault mask
        state_word[`ESCB_B_PEND_HI:`ESCB_B_PEND_LO] = core_view.top_pend;
        state_word[`ESCB_B_RETBASE] = ~core_view.preempted;
        state_word[`ESCB_B_ACT_HI:`ESCB_B_ACT_LO] = core_view.in_handler ? core_view.interrupt_program_status_num
                                                                          : `ESCB_EXC_NONE;
    end
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = `ESCB_RST_WORD;
        if (reg_rd) begin
            case (reg_addr)
                `ESCB_OFF_STATE:  nxt_rdata = state_word;
                `ESCB_OFF_VBASE:  nxt_rdata = vbase_word(tbl_ff);
                `ESCB_OFF_IRQST:  nxt_rdata = {29'h0000000, evt_ff};
                `ESCB_OFF_IRQMSK: nxt_rdata = {29'h0000000, msk_ff};
                default:          nxt_rdata = `ESCB_RST_WORD;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata <= `ESCB_RST_WORD;
        else if (clk_en)
            reg_rdata <= nxt_rdata;
    end
    // mirrors load from the same next state, so pins and internal bits never disagree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_pend  <= 1'b0;
            dsc_pend  <= 1'b0;
            tick_pend <= 1'b0;
        end else if (clk_en) begin
            nmi_pend  <= nxt_nmi;
            dsc_pend  <= nxt_dsc;
            tick_pend <= nxt_tick;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            vector_base <= `ESCB_RST_WORD;
        else if (clk_en)
            vector_base <= vbase_word(nxt_tbl);
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_NMI_SET: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_state && reg_wdata[`ESCB_B_NMI_SET]) |=> nmi_pend_ff)
        else $error("nmi write did not pend");
    AST_NMI_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && nmi_entry && !nmi_rise && !wr_state) |=> !nmi_pend_ff)
        else $error("nmi entry did not clear");
    AST_DSC_SET: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_state && reg_wdata[`ESCB_B_DSC_SET]) |=> dsc_pend_ff)
        else $error("deferred call not pended");
    AST_DSC_ONLY_SW: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(dsc_pend_ff) |-> $past(wr_state && reg_wdata[`ESCB_B_DSC_SET]))
        else $error("deferred call set without write");
    AST_DSC_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_state && reg_wdata[`ESCB_B_DSC_CLR] && !reg_wdata[`ESCB_B_DSC_SET]) |=> !dsc_pend_ff)
        else $error("deferred call not cleared");
    AST_TCK_SET: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_state && reg_wdata[`ESCB_B_TCK_SET]) |=> tick_pend_ff)
        else $error("tick not pended");
    AST_TCK_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_state && reg_wdata[`ESCB_B_TCK_CLR] && !reg_wdata[`ESCB_B_TCK_SET] && !tick_event)
        |=> !tick_pend_ff)
        else $error("tick not cleared");
    AST_STATE_READ: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr == `ESCB_OFF_STATE)
        |=> reg_rdata[`ESCB_B_ACT_HI:`ESCB_B_ACT_LO] == $past(interrupt_program_status_num)
            && reg_rdata[`ESCB_B_RETBASE] == !$past(preempted))
        else $error("state word read wrong");
    AST_VBASE_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
        vector_base[`ESCB_B_TBL_LO-1:0] == 9'h000)
        else $error("vector base low bits set");
    AST_VBASE_WR: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_vbase |=> vector_base[`ESCB_B_TBL_HI:`ESCB_B_TBL_LO]
                     == $past(reg_wdata[`ESCB_B_TBL_HI:`ESCB_B_TBL_LO]))
        else $error("vector base not stored");

    // ----------------------------------------
    // checks: pending state
    // ----------------------------------------
    AST_NMI_PIN: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && nmi_rise) |=> nmi_pend_ff)
        else $error("nmi pin edge did not pend");
    AST_DSC_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && dsc_entry && !(wr_state && reg_wdata[`ESCB_B_DSC_SET])) |=> !dsc_pend_ff)
        else $error("deferred call entry did not clear");
    AST_TCK_EVENT: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && tick_event) |=> tick_pend_ff)
        else $error("tick event did not pend");
    AST_TCK_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && tick_entry && !tick_event && !(wr_state && reg_wdata[`ESCB_B_TCK_SET]))
        |=> !tick_pend_ff)
        else $error("tick entry did not clear");
    AST_PEND_MIRROR: assert property (@(posedge mclk) disable iff (!rst_n)
        nmi_pend == nmi_pend_ff && dsc_pend == dsc_pend_ff && tick_pend == tick_pend_ff)
        else $error("pending outputs disagree with state");
    AST_FREEZE: assert property (@(posedge mclk) disable iff (!rst_n)
        !clk_en |=> $stable(nmi_pend_ff) && $stable(dsc_pend_ff) && $stable(tick_pend_ff)
                    && $stable(evt_ff) && $stable(msk_ff) && $stable(tbl_ff) && $stable(reg_rdata))
        else $error("state moved while frozen");

    // ----------------------------------------
    // checks: interrupt
    // ----------------------------------------
    AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n)
        irq == |(evt_ff & msk_ff))
        else $error("irq level wrong");
    AST_EVT_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && evt_set != `ESCB_RST_EVT)
        |=> (evt_ff & $past(evt_set)) == $past(evt_set))
        else $error("status bit not set by event");
    AST_EVT_RDCLR: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_irqst && evt_set == `ESCB_RST_EVT) |=> evt_ff == `ESCB_RST_EVT)
        else $error("status read did not clear");
    AST_MSK_WR: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_msk |=> msk_ff == $past(reg_wdata[2:0]))
        else $error("mask not stored");

    // ----------------------------------------
    // checks: read port
    // ----------------------------------------
    AST_PEND_RD: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr == `ESCB_OFF_STATE)
        |=> reg_rdata[`ESCB_B_NMI_SET] == $past(nmi_pend_ff) && reg_rdata[`ESCB_B_DSC_SET] == $past(dsc_pend_ff)
            && reg_rdata[`ESCB_B_TCK_SET] == $past(tick_pend_ff))
        else $error("pending bits read wrong");
    AST_ANYPEND_RD: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr == `ESCB_OFF_STATE)
        |=> reg_rdata[`ESCB_B_ANYPEND] == $past(ext_irq_pend || dsc_pend_ff || tick_pend_ff))
        else $error("any pending flag wrong");
    AST_TOP_PEND_RD: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr == `ESCB_OFF_STATE)
        |=> reg_rdata[`ESCB_B_PEND_HI:`ESCB_B_PEND_LO] == $past(top_pend))
        else $error("top pending number wrong");
    AST_DEBUG_RD: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr == `ESCB_OFF_STATE && !debug_state)
        |=> !reg_rdata[`ESCB_B_DEBUG])
        else $error("debug bit not zero");
    AST_RSVD_RD: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr == `ESCB_OFF_STATE)
        |=> (reg_rdata & `ESCB_STATE_RSVD) == `ESCB_RST_WORD)
        else $error("reserved state bits not zero");
    AST_VBASE_RD: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr == `ESCB_OFF_VBASE)
        |=> reg_rdata == vbase_word($past(tbl_ff)))
        else $error("vector base read wrong");
    AST_UNMAPPED_RD: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr != `ESCB_OFF_STATE && reg_addr != `ESCB_OFF_VBASE
         && reg_addr != `ESCB_OFF_IRQST && reg_addr != `ESCB_OFF_IRQMSK)
        |=> reg_rdata == `ESCB_RST_WORD)
        else $error("unmapped read not zero");
    AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && !reg_rd) |=> reg_rdata == `ESCB_RST_WORD)
        else $error("read data not zero when idle");
    AST_VBASE_MIRROR: assert property (@(posedge mclk) disable iff (!rst_n)
        vector_base == vbase_word(tbl_ff))
        else $error("vector base output disagrees");
endmodule

// ==== test/tb_escb_ctrl.sv ====
`timescale 1ns/1ps
`include "escb_cfg.svh"
module tb_escb_ctrl
    import escb_pkg::*;
;
    logic        mclk, rst_n, clk_en, reg_wr, reg_rd, nmi_pin, preempted, top_is_fault, ext_irq_pend;
    logic        debug_state, nmi_pend, dsc_pend, tick_pend, irq;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, vector_base, d;
    logic [8:0]  interrupt_program_status_num, top_pend;
    logic [3:0]  ev;
    logic [19:0] tbl [3];
    int          num_errors, n_compared;

    escb_ctrl i_escb_ctrl (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nmi_pin(nmi_pin), .nmi_entry(ev[0]), .dsc_entry(ev[1]), .tick_event(ev[2]),
        .tick_entry(ev[3]), .interrupt_program_status_num(interrupt_program_status_num), .preempted(preempted), .top_pend(top_pend),
        .top_is_fault(top_is_fault), .ext_irq_pend(ext_irq_pend), .debug_state(debug_state),
        .nmi_pend(nmi_pend), .dsc_pend(dsc_pend), .tick_pend(tick_pend),
        .vector_base(vector_base), .irq(irq));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // strobes last one cycle; trailing delay lets registered outputs settle
    task wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= w;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge mclk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask
    task pulse(input logic [3:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 4'h0;
        #1;
    endtask
    function automatic logic [31:0] exp_st(input logic n, input logic s, input logic t);
        exp_st = 32'h0;
        exp_st[31] = n; exp_st[28] = s; exp_st[26] = t;
        exp_st[22] = ext_irq_pend | s | t;
        exp_st[20:12] = top_pend; exp_st[11] = ~preempted; exp_st[8:0] = interrupt_program_status_num;
    endfunction

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        test_done;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, nmi_pin, preempted, top_is_fault, ext_irq_pend, debug_state} = 8'h00;
        {reg_addr, reg_wdata, interrupt_program_status_num, top_pend, ev} = '0;
        clk_en = 1'b1; num_errors = 0; n_compared = 0;
        tbl[0] = 20'hFFC07; tbl[1] = 20'h01DF0; tbl[2] = 20'h02006;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`ESCB_OFF_STATE, d); chk(d, exp_st(0, 0, 0));
        rd(`ESCB_OFF_VBASE, d); chk(d, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            {interrupt_program_status_num, top_pend, preempted, ext_irq_pend} <= tbl[i];
            rd(`ESCB_OFF_STATE, d); chk(d, exp_st(0, 0, 0));
        end
        @(posedge mclk);
        {interrupt_program_status_num, top_pend, preempted, ext_irq_pend} <= 20'h0;
        $display("test fields done");
        rd(`ESCB_OFF_IRQST, d);
        wr(`ESCB_OFF_IRQMSK, 32'h7);
        wr(`ESCB_OFF_STATE, 32'h1000_0000); chk(dsc_pend, 1'b1);
        chk(irq, 1'b1);
        rd(`ESCB_OFF_STATE, d); chk(d, exp_st(0, 1, 0));
        rd(`ESCB_OFF_IRQST, d); chk(d, 32'h2);
        chk(irq, 1'b0);
        wr(`ESCB_OFF_STATE, 32'h0000_0000); chk(dsc_pend, 1'b1);
        wr(`ESCB_OFF_STATE, 32'h0800_0000); chk(dsc_pend, 1'b0);
        pulse(4'h4); chk(dsc_pend, 1'b0);
        chk(tick_pend, 1'b1);
        pulse(4'h8); chk(tick_pend, 1'b0);
        wr(`ESCB_OFF_STATE, 32'h1000_0000);
        pulse(4'h2); chk(dsc_pend, 1'b0);
        $display("test deferred done");
        wr(`ESCB_OFF_STATE, 32'h0400_0000); chk(tick_pend, 1'b1);
        rd(`ESCB_OFF_STATE, d); chk(d, exp_st(0, 0, 1));
        wr(`ESCB_OFF_STATE, 32'h0200_0000); chk(tick_pend, 1'b0);
        $display("test tick done");
        wr(`ESCB_OFF_STATE, 32'h8000_0000); chk(nmi_pend, 1'b1);
        rd(`ESCB_OFF_STATE, d); chk(d, exp_st(1, 0, 0));
        pulse(4'h1); chk(nmi_pend, 1'b0);
        @(posedge mclk);
        nmi_pin <= 1'b1;
        repeat (6) @(posedge mclk);
        #1 chk(nmi_pend, 1'b1);
        pulse(4'h1);
        @(posedge mclk);
        nmi_pin <= 1'b0;
        $display("test unmaskable done");
        rd(`ESCB_OFF_IRQST, d);
        wr(`ESCB_OFF_IRQMSK, 32'h0);
        pulse(4'h4); chk(irq, 1'b0);
        rd(`ESCB_OFF_IRQST, d); chk(d, 32'h4);
        rd(`ESCB_OFF_IRQMSK, d); chk(d, 32'h0);
        pulse(4'h8);
        $display("test interrupt done");
        wr(`ESCB_OFF_VBASE, 32'hFFFF_FFFF);
        rd(`ESCB_OFF_VBASE, d); chk(d, 32'hFFFF_FE00);
        chk(vector_base, 32'hFFFF_FE00);
        wr(`ESCB_OFF_VBASE, 32'h0000_0400);
        rd(`ESCB_OFF_VBASE, d); chk(d, 32'h0000_0400);
        $display("test vector base done");
        wr(`ESCB_OFF_IRQMSK, 32'h7);
        wr(`ESCB_OFF_STATE, 32'h0400_0000); chk(irq, 1'b1);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk(tick_pend, 1'b0);
        chk(vector_base, 32'h0);
        chk(irq, 1'b0);
        rd(`ESCB_OFF_IRQMSK, d); chk(d, 32'h0);
        $display("test mid reset done");
        wr(`ESCB_OFF_STATE, 32'h61FF_FFFF);
        rd(`ESCB_OFF_STATE, d); chk(d, exp_st(0, 0, 0));
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, d); chk(d, 32'h0);
        @(posedge mclk);
        clk_en <= 1'b0;
        wr(`ESCB_OFF_STATE, 32'h1000_0000);
        @(posedge mclk);
        clk_en <= 1'b1;
        #1 chk(dsc_pend, 1'b0);
        $display("test reserved done");
        test_done;
    end
endmodule
